//--- verilog/leu_params.svh
// Contract
// - Rising-edge enable bit makes a rising edge trigger interrupt and event.
// - Falling-edge enable bit makes a falling edge trigger interrupt and event.
// - Both enables set: every edge of either direction triggers separately.
// - Rising edge during a rising-select write still sets pending.
// - Falling edge during a falling-select write does not set pending.
// - Writing one to a clear software kick bit sets unmasked pending.
// - Software kick bit stays set until its pending flag is cleared.
// - Pending flag sets on selected edge; zero means no trigger seen.
// - Pending flag clears only by writing one; zero leaves it.
// - Edge selects and kick register at 0x08, 0x0C, 0x10, reset zero.
// - Pending register at 0x14; reset clears every flag to zero.
// - Interrupt mask bit per line: one passes request, zero blocks.
// - Event mask bit per line: one passes event, zero blocks.
// - Unmasked event path emits one pulse, never sets pending.
// - Unmasked interrupt path raises request and sets pending flag.
`ifndef LEU_PARAMS_SVH
`define LEU_PARAMS_SVH
// ==========================================================
// Register offsets
`define LEU_OFF_IMASK 8'h00
`define LEU_OFF_EMASK 8'h04
`define LEU_OFF_RISE 8'h08
`define LEU_OFF_FALL 8'h0C
`define LEU_OFF_KICK 8'h10
`define LEU_OFF_PEND 8'h14
// ==========================================================
// Field layout and reset values
`define LEU_LINES 23
`define LEU_IMPL_MASK 23'h67FFFF
`define LEU_RESET_ZERO 23'h000000
`endif

//--- verilog/leu_pkg.sv
`default_nettype none
package leu_pkg;
  typedef logic [22:0] leu_lines_t;
  typedef enum logic [2:0] {
    LEU_SEL_IMASK,
    LEU_SEL_EMASK,
    LEU_SEL_RISE,
    LEU_SEL_FALL,
    LEU_SEL_KICK,
    LEU_SEL_PEND,
    LEU_SEL_NONE
  } leu_sel_t;
endpackage
`default_nettype wire

//--- verilog/leu_edge_detect.sv
`include "leu_params.svh"
`default_nettype none
module leu_edge_detect (
  input wire logic ref_clk,
  input wire logic srst,
  input wire leu_pkg::leu_lines_t line_in,
  output leu_pkg::leu_lines_t rise,
  output leu_pkg::leu_lines_t fall
);
  leu_pkg::leu_lines_t line_prev;

  // ==========================================================
  // Registered copy
  // Loaded with the live level in reset so a line that is already
  // high does not fake a rising edge on the first cycle.
  always_ff @(posedge ref_clk) begin
    line_prev <= line_in;
  end

  // No edge is reported while reset is held
  wire leu_pkg::leu_lines_t live = `LEU_IMPL_MASK & {23{~srst}};

  assign rise = line_in & ~line_prev & live;
  assign fall = ~line_in & line_prev & live;
endmodule
`default_nettype wire

//--- verilog/leu_top.sv
`include "leu_params.svh"
`default_nettype none
module leu_top (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire leu_pkg::leu_lines_t line_in,
  output leu_pkg::leu_lines_t irq_req,
  output leu_pkg::leu_lines_t event_pulse
);
  leu_pkg::leu_lines_t imask;
  leu_pkg::leu_lines_t emask;
  leu_pkg::leu_lines_t rise_sel;
  leu_pkg::leu_lines_t fall_sel;
  leu_pkg::leu_lines_t soft_line_kick;
  leu_pkg::leu_lines_t pending;
  leu_pkg::leu_lines_t rise;
  leu_pkg::leu_lines_t fall;

  // ==========================================================
  // Address decode
  function automatic leu_pkg::leu_sel_t decode(input logic [7:0] addr);
    leu_pkg::leu_sel_t sel;
    sel = leu_pkg::LEU_SEL_NONE;
    unique case (addr)
      `LEU_OFF_IMASK: sel = leu_pkg::LEU_SEL_IMASK;
      `LEU_OFF_EMASK: sel = leu_pkg::LEU_SEL_EMASK;
      `LEU_OFF_RISE: sel = leu_pkg::LEU_SEL_RISE;
      `LEU_OFF_FALL: sel = leu_pkg::LEU_SEL_FALL;
      `LEU_OFF_KICK: sel = leu_pkg::LEU_SEL_KICK;
      `LEU_OFF_PEND: sel = leu_pkg::LEU_SEL_PEND;
      default: sel = leu_pkg::LEU_SEL_NONE;
    endcase
    return sel;
  endfunction

  wire logic setup_ph = psel & ~penable;
  wire logic access_wr = psel & penable & pwrite;
  wire leu_pkg::leu_sel_t sel = decode(paddr);
  wire leu_pkg::leu_lines_t wdata = pwdata[22:0] & `LEU_IMPL_MASK;
  wire logic wr_imask = access_wr && sel == leu_pkg::LEU_SEL_IMASK;
  wire logic wr_emask = access_wr && sel == leu_pkg::LEU_SEL_EMASK;
  wire logic wr_rise = access_wr && sel == leu_pkg::LEU_SEL_RISE;
  wire logic wr_fall = access_wr && sel == leu_pkg::LEU_SEL_FALL;
  wire logic wr_kick = access_wr && sel == leu_pkg::LEU_SEL_KICK;
  wire logic wr_pend = access_wr && sel == leu_pkg::LEU_SEL_PEND;

  // ==========================================================
  // Trigger selection
  leu_edge_detect u_edge (
    .ref_clk(ref_clk),
    .srst(srst),
    .line_in(line_in),
    .rise(rise),
    .fall(fall)
  );

  // Old or new select both count, so a write never hides a rising edge
  wire leu_pkg::leu_lines_t rise_en =
    rise_sel | (wr_rise ? wdata : `LEU_RESET_ZERO);
  // Falling edges are dropped for the whole write cycle
  wire leu_pkg::leu_lines_t fall_en =
    wr_fall ? `LEU_RESET_ZERO : fall_sel;
  wire leu_pkg::leu_lines_t rise_trig = rise & rise_en;
  wire leu_pkg::leu_lines_t fall_trig = fall & fall_en;
  wire leu_pkg::leu_lines_t hw_trig = rise_trig | fall_trig;
  wire leu_pkg::leu_lines_t kick_new =
    wr_kick ? (wdata & ~soft_line_kick) : `LEU_RESET_ZERO;
  wire leu_pkg::leu_lines_t any_trig = hw_trig | kick_new;

  // ==========================================================
  // Pending, kick and outputs
  wire leu_pkg::leu_lines_t pend_clr =
    wr_pend ? wdata : `LEU_RESET_ZERO;
  wire leu_pkg::leu_lines_t pend_set = any_trig & imask;
  // Set wins over a clear landing in the same cycle
  wire leu_pkg::leu_lines_t next_pending =
    (pending & ~pend_clr) | pend_set;
  wire leu_pkg::leu_lines_t next_kick =
    (soft_line_kick | kick_new) & ~pend_clr;
  wire leu_pkg::leu_lines_t next_event = any_trig & emask;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      imask <= `LEU_RESET_ZERO;
      emask <= `LEU_RESET_ZERO;
      rise_sel <= `LEU_RESET_ZERO;
      fall_sel <= `LEU_RESET_ZERO;
      soft_line_kick <= `LEU_RESET_ZERO;
      pending <= `LEU_RESET_ZERO;
      irq_req <= `LEU_RESET_ZERO;
      event_pulse <= `LEU_RESET_ZERO;
    end else begin
      if (wr_imask) begin
        imask <= wdata;
      end
      if (wr_emask) begin
        emask <= wdata;
      end
      if (wr_rise) begin
        rise_sel <= wdata;
      end
      if (wr_fall) begin
        fall_sel <= wdata;
      end
      soft_line_kick <= next_kick;
      pending <= next_pending;
      irq_req <= next_pending & imask;
      event_pulse <= next_event;
    end
  end

  // ==========================================================
  // Bus answer
  // Read data is caught in the setup phase so it is a flop output in
  // the access phase; the access phase never waits.
  wire leu_pkg::leu_lines_t rd_mux =
    sel == leu_pkg::LEU_SEL_IMASK ? imask :
    sel == leu_pkg::LEU_SEL_EMASK ? emask :
    sel == leu_pkg::LEU_SEL_RISE ? rise_sel :
    sel == leu_pkg::LEU_SEL_FALL ? fall_sel :
    sel == leu_pkg::LEU_SEL_KICK ? soft_line_kick :
    sel == leu_pkg::LEU_SEL_PEND ? pending : `LEU_RESET_ZERO;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (setup_ph) begin
        prdata <= {9'h000, rd_mux & `LEU_IMPL_MASK};
        pslverr <= sel == leu_pkg::LEU_SEL_NONE;
      end
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);

  wire leu_pkg::leu_lines_t rise_irq = rise_trig & imask;
  wire leu_pkg::leu_lines_t fall_irq = fall_trig & imask;
  wire leu_pkg::leu_lines_t both_irq = (rise | fall) & rise_sel &
    fall_sel & imask;
  wire leu_pkg::leu_lines_t kick_irq = wdata & ~soft_line_kick & imask;
  wire leu_pkg::leu_lines_t rise_ev = rise_trig & emask;
  wire leu_pkg::leu_lines_t kept = pending & ~wdata;

  rise_pend_a: assert property (
    rise_irq != 0 |=> (pending & $past(rise_irq)) == $past(rise_irq))
    else $error("rising edge did not set pending");
  fall_pend_a: assert property (
    !wr_fall && fall_irq != 0 |=>
    (irq_req & $past(fall_irq)) == $past(fall_irq))
    else $error("falling edge did not raise request");
  both_edges_a: assert property (
    !wr_rise && !wr_fall && both_irq != 0 |=>
    (pending & $past(both_irq)) == $past(both_irq))
    else $error("edge lost with both selects set");
  rise_write_a: assert property (
    wr_rise && (rise & rise_sel & imask) != 0 |=> pending != 0)
    else $error("rising edge lost during select write");
  fall_write_a: assert property (
    wr_fall && pending == 0 && (rise_trig & imask) == 0 |=> pending == 0)
    else $error("falling edge set pending during write");
  soft_kick_a: assert property (
    wr_kick && kick_irq != 0 |=>
    (irq_req & $past(kick_irq)) == $past(kick_irq))
    else $error("software kick raised no request");
  kick_clear_a: assert property (
    wr_pend |=> (soft_line_kick & $past(wdata)) == 0)
    else $error("kick bit survived pending clear");
  zero_write_a: assert property (
    wr_pend |=> (pending & $past(kept)) == $past(kept))
    else $error("write of zero cleared a flag");
  irq_follow_a: assert property (
    irq_req == (pending & $past(imask)))
    else $error("request does not follow pending and mask");
  event_pulse_a: assert property (
    rise_ev != 0 && (rise & $past(rise)) == 0 |=>
    (event_pulse & $past(rise_ev)) == $past(rise_ev) ##1
    (event_pulse & $past(rise_ev, 2) & ~$past(next_event)) == 0)
    else $error("event not a single pulse");
  unimpl_zero_a: assert property (
    (prdata[22:0] & ~`LEU_IMPL_MASK) == 0 && prdata[31:23] == 9'h000)
    else $error("unimplemented bits read nonzero");

  rise_irq_c: cover property (rise_irq != 0 ##1 irq_req != 0);
  kick_c: cover property (wr_kick && kick_irq != 0);
  clear_c: cover property (wr_pend && (pending & wdata) != 0);
  event_c: cover property (event_pulse != 0);
endmodule
`default_nettype wire

//--- bench/leu_core_model.sv
`default_nettype none
module leu_core_model (
  input wire logic ref_clk,
  input wire logic srst,
  input wire leu_pkg::leu_lines_t irq_req,
  input wire leu_pkg::leu_lines_t event_pulse,
  output var int ev_seen,
  output var leu_pkg::leu_lines_t irq_seen
);
  timeunit 1ns;
  timeprecision 100ps;
  // ========================================
  // Core side: counts wake pulses, keeps every request seen
  always @(posedge ref_clk) begin
    if (srst) begin
      ev_seen <= 0;
      irq_seen <= '0;
    end else begin
      ev_seen <= ev_seen + $countones(event_pulse);
      irq_seen <= irq_seen | irq_req;
    end
  end
endmodule
`default_nettype wire

//--- bench/tb.sv
`include "leu_params.svh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk, srst, psel, penable, pwrite, wiggle, pready, pslverr;
  logic m_err, wr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, m_rd;
  leu_pkg::leu_lines_t line_in, irq_req, event_pulse, irq_seen, irq_any;
  leu_pkg::leu_lines_t m_im, m_em, m_ri, m_fa, m_kk, m_pd, m_prev;
  leu_pkg::leu_lines_t e_irq, e_ev, trig, wv, clr;
  int err_count, checks_done, ev_exp, ev_seen;
  leu_top u_dut (.ref_clk(ref_clk), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .line_in(line_in), .irq_req(irq_req), .event_pulse(event_pulse));
  leu_core_model u_core (.ref_clk(ref_clk), .srst(srst), .irq_req(irq_req),
    .event_pulse(event_pulse), .ev_seen(ev_seen), .irq_seen(irq_seen));
  // ========================================
  // Clock, watchdog, compare and verdict
  initial begin
    ref_clk = 0;
    forever #50 ref_clk = ~ref_clk;
  end
  initial begin
    #5_000_000;
    err_count++;
    conclude();
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ========================================
  // Reference model, one step per edge, old masks used this edge
  always @(posedge ref_clk) begin
    if (srst) begin
      {m_im, m_em, m_ri, m_fa, m_kk, m_pd, e_irq, e_ev, irq_any} = '0;
      {m_rd, m_err, ev_exp} = '0;
      m_prev = line_in;
    end else begin
      if (psel && !penable) begin
        m_err = paddr > `LEU_OFF_PEND;
        case (paddr)
          `LEU_OFF_IMASK: m_rd = {9'h0, m_im};
          `LEU_OFF_EMASK: m_rd = {9'h0, m_em};
          `LEU_OFF_RISE: m_rd = {9'h0, m_ri};
          `LEU_OFF_FALL: m_rd = {9'h0, m_fa};
          `LEU_OFF_KICK: m_rd = {9'h0, m_kk};
          `LEU_OFF_PEND: m_rd = {9'h0, m_pd};
          default: m_rd = '0;
        endcase
      end
      wr = psel && penable && pwrite;
      wv = pwdata[22:0] & `LEU_IMPL_MASK;
      trig = (wr && paddr == `LEU_OFF_RISE) ? wv : '0;
      trig = line_in & ~m_prev & (m_ri | trig);
      if (!(wr && paddr == `LEU_OFF_FALL)) trig |= ~line_in & m_prev & m_fa;
      if (wr && paddr == `LEU_OFF_KICK) begin
        trig |= wv & ~m_kk;
        m_kk |= wv;
      end
      trig &= `LEU_IMPL_MASK;
      clr = (wr && paddr == `LEU_OFF_PEND) ? wv : '0;
      e_ev = trig & m_em;
      ev_exp += $countones(e_ev);
      m_pd = (m_pd & ~clr) | (trig & m_im);
      m_kk &= ~clr;
      e_irq = m_pd & m_im;
      irq_any |= e_irq;
      if (wr && paddr == `LEU_OFF_IMASK) m_im = wv;
      if (wr && paddr == `LEU_OFF_EMASK) m_em = wv;
      if (wr && paddr == `LEU_OFF_RISE) m_ri = wv;
      if (wr && paddr == `LEU_OFF_FALL) m_fa = wv;
      m_prev = line_in;
    end
  end
  always @(negedge ref_clk) begin
    if (!srst) begin
      check({9'h0, irq_req}, {9'h0, e_irq});
      check({9'h0, event_pulse}, {9'h0, e_ev});
    end
  end
  // Lines move only just after an edge, so no glitch is ever seen
  always @(posedge ref_clk) begin
    #1;
    if (wiggle) line_in = line_in ^ 23'($urandom & $urandom & $urandom);
  end
  // ========================================
  // Register access, zero wait states, read data checked at access edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk) #1;
    {psel, penable, pwrite, paddr, pwdata} = {1'b1, 1'b0, w, a, d};
    @(posedge ref_clk) #1;
    penable = 1;
    @(posedge ref_clk);
    check({31'h0, pready}, 32'h1);
    if (!w) begin
      check(prdata, m_rd);
      check({31'h0, pslverr}, {31'h0, m_err});
    end
    #1 {psel, penable} = 2'b00;
  endtask
  initial begin
    {srst, psel, penable, pwrite, wiggle} = 5'h10;
    {paddr, pwdata, line_in} = '0;
    {err_count, checks_done} = '0;
    void'($urandom(32'h483321d3));
    repeat (20) @(posedge ref_clk);
    #1 srst = 0;
    for (int a = 0; a <= 8'h18; a += 4) apb(0, 8'(a), 0);
    apb(1, `LEU_OFF_RISE, 32'h007FFFFF);
    apb(0, `LEU_OFF_RISE, 0);
    apb(1, 8'h18, 32'hFFFFFFFF);
    apb(1, `LEU_OFF_RISE, 0);
    wiggle = 1;
    // Random masks and selects while lines toggle, writes meet edges
    repeat (12) begin
      for (int a = 0; a < 16; a += 4) begin
        apb(1, 8'(a), $urandom & 32'h7FFFFF);
      end
      repeat (15) @(posedge ref_clk);
      apb(0, `LEU_OFF_PEND, 0);
      apb(1, `LEU_OFF_PEND, $urandom & 32'h7FFFFF);
      apb(0, `LEU_OFF_PEND, 0);
    end
    wiggle = 0;
    apb(1, `LEU_OFF_PEND, 32'h7FFFFF);
    apb(1, `LEU_OFF_IMASK, $urandom & 32'h7FFFFF);
    apb(1, `LEU_OFF_EMASK, $urandom & 32'h7FFFFF);
    repeat (3) begin
      apb(1, `LEU_OFF_KICK, $urandom & 32'h7FFFFF);
      apb(0, `LEU_OFF_KICK, 0);
      apb(0, `LEU_OFF_PEND, 0);
    end
    apb(1, `LEU_OFF_PEND, $urandom & 32'h7FFFFF);
    apb(0, `LEU_OFF_KICK, 0);
    repeat (2) @(posedge ref_clk);
    check({9'h0, irq_seen}, {9'h0, irq_any});
    check(32'(ev_seen), 32'(ev_exp));
    conclude();
  end
endmodule
`default_nettype wire
